// File: verilog/rxmt_pkg.sv
// Constants shared by the receive-mask and no-response timer block
package rxmt_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_RX_MASK_TIME     = 6'h0E;
	localparam logic [5:0] IDX_RESP_TIMEOUT_HI  = 6'h0F;
	localparam logic [5:0] IDX_RESP_TIMEOUT_LO  = 6'h10;
	localparam logic [5:0] IDX_TIMER_CTRL       = 6'h18;
	localparam logic [5:0] IDX_COMMAND          = 6'h19;
	localparam logic [5:0] IDX_IRQ_STATUS       = 6'h1A;
	localparam logic [5:0] IDX_IRQ_MASK         = 6'h1B;
	localparam logic [5:0] IDX_TIMER_STATUS     = 6'h1C;

	// Reset values
	localparam logic [7:0] RX_MASK_TIME_RESET   = 8'h08;
	localparam logic [7:0] RESP_TIMEOUT_RESET   = 8'h00;
	localparam logic [7:0] TIMER_CTRL_RESET     = 8'h00;
	localparam logic [1:0] IRQ_MASK_RESET       = 2'h0;

	// Timer control fields
	localparam int CTRL_NRT_LONG_STEP = 0;
	localparam int CTRL_BITRATE_DET   = 1;
	localparam int CTRL_ISO_A_106     = 2;
	localparam int CTRL_NFC_MODE      = 3;
	localparam int CTRL_ACTIVE_MODE   = 4;
	localparam int CTRL_AUTO_SQUELCH  = 5;

	// Command fields
	localparam int CMD_START_NRT   = 0;
	localparam int CMD_SET_DEFAULT = 1;

	// Interrupt fields
	localparam int IRQ_NO_RESPONSE = 0;
	localparam int IRQ_MASK_DONE   = 1;

	// Timer status fields
	localparam int STAT_MASKING  = 0;
	localparam int STAT_NRT_RUN  = 1;
	localparam int STAT_SQUELCH  = 2;
	localparam int STAT_FIELD    = 3;
	localparam int STAT_NRT_WAIT = 4;

	// Timer steps in carrier periods, and minimum mask counts in steps
	localparam logic [12:0] STEP_MASK       = 13'h0040;
	localparam logic [12:0] STEP_MASK_HALF  = 13'h0020;
	localparam logic [12:0] STEP_MASK_BRD   = 13'h0200;
	localparam logic [12:0] STEP_NRT_SHORT  = 13'h0040;
	localparam logic [12:0] STEP_NRT_LONG   = 13'h1000;
	localparam logic [7:0]  MASK_MIN_COUNT  = 8'h04;
	localparam logic [8:0]  MASK_MIN_HALF   = 9'h008;

	// Squelch start delay after end of transmission
	localparam int CLK_PERIOD_PS      = 8000;
	localparam int SQUELCH_DELAY_PS   = 18880000;
	localparam int SQUELCH_DELAY_CYC  = (SQUELCH_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// No-response start sequencer
	typedef enum logic [1:0] {
		RXMT_NRT_IDLE = 2'h0,
		RXMT_NRT_WAIT = 2'h1,
		RXMT_NRT_RUN  = 2'h3
	} rxmt_nrt_state_type;

endpackage : rxmt_pkg

// File: verilog/rxmt_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module rxmt_sync (
	// Clock and control
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// Level
	input  wire logic async_in,
	output var  logic sync_out
);

	logic stage1_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_reg <= 1'b0;
			sync_out   <= 1'b0;
		end else if (ce) begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule : rxmt_sync
`default_nettype wire

// File: verilog/rxmt_step_timer.sv
// Down counter advanced once per step of carrier ticks
`timescale 1ns/1ps
`default_nettype none
module rxmt_step_timer (
	// Clock and control
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// Timing
	input  wire logic        carrier_tick,
	input  wire logic [12:0] step_len,
	input  wire logic [15:0] load_count,
	// Commands
	input  wire logic        start,
	input  wire logic        stop,
	// State
	output var  logic        running,
	output var  logic        expired
);

	logic [12:0] pre_reg;
	logic [15:0] cnt_reg;

	wire step_done  = running && carrier_tick && (pre_reg == step_len - 13'h0001);
	wire last_count = (cnt_reg == 16'h0001);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_reg <= 13'h0000;
			cnt_reg <= 16'h0000;
			running <= 1'b0;
			expired <= 1'b0;
		end else if (ce) begin
			expired <= 1'b0;
			if (start) begin
				pre_reg <= 13'h0000;
				cnt_reg <= load_count;
				running <= (load_count != 16'h0000);
			end else if (stop) begin
				running <= 1'b0;
			end else if (step_done) begin
				pre_reg <= 13'h0000;
				cnt_reg <= cnt_reg - 16'h0001;
				running <= !last_count;
				expired <= last_count;
			end else if (running && carrier_tick) begin
				pre_reg <= pre_reg + 13'h0001;
			end
		end
	end

endmodule : rxmt_step_timer
`default_nettype wire

// File: verilog/rxmt_timers.sv
// Receive-mask and no-response timers with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module rxmt_timers (
	// Clock, reset, clock enable
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// AXI4-Lite write address
	input  wire logic [7:0] s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output var  logic       s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Framing events on this clock
	input  wire logic        carrier_tick,
	input  wire logic        tx_end,
	input  wire logic        rx_response,
	// Analog front end levels
	input  wire logic        ext_field_in,
	input  wire logic        rx_data_in,
	// Outputs
	output var  logic        rx_data_out,
	output var  logic        squelch_out,
	output var  logic        irq
);

	// Registers
	logic [7:0]  rx_mask_time_reg;
	logic [7:0]  response_timeout_high_reg;
	logic [7:0]  response_timeout_low_reg;
	logic [7:0]  timer_ctrl_reg;
	logic [1:0]  irq_status_reg;
	logic [1:0]  irq_mask_reg;
	logic [7:0]  aw_index_reg;
	logic [7:0]  w_data_reg;
	logic        w_strb_reg;
	logic [11:0] squelch_cnt_reg;
	rxmt_pkg::rxmt_nrt_state_type nrt_state_reg;
	rxmt_pkg::rxmt_nrt_state_type nrt_state_next;

	// Synchronised pins and timer states
	logic ext_field_sync;
	logic rx_data_sync;
	logic mask_running;
	logic mask_expired;
	logic nrt_running;
	logic nrt_expired;

	rxmt_sync u_field_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.async_in (ext_field_in),
		.sync_out (ext_field_sync)
	);

	rxmt_sync u_rx_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.async_in (rx_data_in),
		.sync_out (rx_data_sync)
	);

	// Bus handshakes and decode
	wire       aw_hs      = s_axi_awvalid && s_axi_awready;
	wire       w_hs       = s_axi_wvalid && s_axi_wready;
	wire       ar_hs      = s_axi_arvalid && s_axi_arready;
	wire       do_write   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire [5:0] wr_index   = aw_index_reg[5:0];
	wire [5:0] rd_index   = s_axi_araddr[7:2];
	wire       wr_lane    = do_write && w_strb_reg;
	wire       wr_mask    = wr_lane && (wr_index == rxmt_pkg::IDX_RX_MASK_TIME);
	wire       wr_nrt_hi  = wr_lane && (wr_index == rxmt_pkg::IDX_RESP_TIMEOUT_HI);
	wire       wr_nrt_lo  = wr_lane && (wr_index == rxmt_pkg::IDX_RESP_TIMEOUT_LO);
	wire       wr_ctrl    = wr_lane && (wr_index == rxmt_pkg::IDX_TIMER_CTRL);
	wire       wr_cmd     = wr_lane && (wr_index == rxmt_pkg::IDX_COMMAND);
	wire       wr_istat   = wr_lane && (wr_index == rxmt_pkg::IDX_IRQ_STATUS);
	wire       wr_imask   = wr_lane && (wr_index == rxmt_pkg::IDX_IRQ_MASK);
	wire       wr_mapped  = (wr_index == rxmt_pkg::IDX_RX_MASK_TIME) || (wr_index == rxmt_pkg::IDX_RESP_TIMEOUT_HI)
	                     || (wr_index == rxmt_pkg::IDX_RESP_TIMEOUT_LO) || (wr_index == rxmt_pkg::IDX_TIMER_CTRL)
	                     || (wr_index == rxmt_pkg::IDX_COMMAND) || (wr_index == rxmt_pkg::IDX_IRQ_STATUS)
	                     || (wr_index == rxmt_pkg::IDX_IRQ_MASK) || (wr_index == rxmt_pkg::IDX_TIMER_STATUS);
	wire       cmd_start  = wr_cmd && w_data_reg[rxmt_pkg::CMD_START_NRT];
	wire       cmd_default = wr_cmd && w_data_reg[rxmt_pkg::CMD_SET_DEFAULT];

	// Mode selects
	wire bitrate_det = timer_ctrl_reg[rxmt_pkg::CTRL_BITRATE_DET];
	wire iso_a_106   = timer_ctrl_reg[rxmt_pkg::CTRL_ISO_A_106];
	wire nfc_mode    = timer_ctrl_reg[rxmt_pkg::CTRL_NFC_MODE];
	wire auto_sq     = timer_ctrl_reg[rxmt_pkg::CTRL_AUTO_SQUELCH];

	wire [7:0] mask_clamped = (rx_mask_time_reg < rxmt_pkg::MASK_MIN_COUNT) ? rxmt_pkg::MASK_MIN_COUNT
	                        : rx_mask_time_reg;
	// half-step units, never below 256 carrier periods
	wire [8:0] mask_half    = ({1'b0, rx_mask_time_reg} < rxmt_pkg::MASK_MIN_HALF) ? rxmt_pkg::MASK_MIN_HALF
	                        : {1'b0, rx_mask_time_reg};
	wire [12:0] mask_step   = bitrate_det ? rxmt_pkg::STEP_MASK_BRD
	                        : iso_a_106 ? rxmt_pkg::STEP_MASK_HALF : rxmt_pkg::STEP_MASK;
	wire [15:0] mask_load   = (iso_a_106 && !bitrate_det) ? {7'h00, mask_half} : {8'h00, mask_clamped};

	wire [15:0] nrt_count   = {response_timeout_high_reg, response_timeout_low_reg};
	wire [12:0] nrt_step    = timer_ctrl_reg[rxmt_pkg::CTRL_NRT_LONG_STEP] ? rxmt_pkg::STEP_NRT_LONG
	                        : rxmt_pkg::STEP_NRT_SHORT;
	wire        nrt_armable = (nrt_count != 16'h0000);

	rxmt_step_timer u_mask_timer (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.carrier_tick (carrier_tick),
		.step_len     (mask_step),
		.load_count   (mask_load),
		.start        (tx_end),
		.stop         (cmd_default),
		.running      (mask_running),
		.expired      (mask_expired)
	);

	// No-response start sequencing
	wire nrt_start_field = (nrt_state_reg == rxmt_pkg::RXMT_NRT_WAIT) && ext_field_sync;
	wire nrt_load  = nrt_armable && (cmd_start || nrt_start_field
	              || (tx_end && !nfc_mode) || (tx_end && nfc_mode && ext_field_sync));
	wire nrt_stop  = rx_response || cmd_default;

	always_comb begin
		nrt_state_next = nrt_state_reg;
		case (nrt_state_reg)
			rxmt_pkg::RXMT_NRT_IDLE: begin
				if (tx_end && nfc_mode && !ext_field_sync && nrt_armable)
					nrt_state_next = rxmt_pkg::RXMT_NRT_WAIT;
				else if (nrt_load)
					nrt_state_next = rxmt_pkg::RXMT_NRT_RUN;
			end
			rxmt_pkg::RXMT_NRT_WAIT: begin
				if (nrt_stop)
					nrt_state_next = rxmt_pkg::RXMT_NRT_IDLE;
				else if (nrt_load)
					nrt_state_next = rxmt_pkg::RXMT_NRT_RUN;
			end
			rxmt_pkg::RXMT_NRT_RUN: begin
				if (nrt_load)
					nrt_state_next = rxmt_pkg::RXMT_NRT_RUN;
				else if (nrt_stop || nrt_expired)
					nrt_state_next = rxmt_pkg::RXMT_NRT_IDLE;
			end
			default: nrt_state_next = rxmt_pkg::RXMT_NRT_IDLE;
		endcase
	end

	rxmt_step_timer u_nrt_timer (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.carrier_tick (carrier_tick),
		.step_len     (nrt_step),
		.load_count   (nrt_count),
		.start        (nrt_load),
		.stop         (nrt_stop),
		.running      (nrt_running),
		.expired      (nrt_expired)
	);

	// Interrupt status, set wins over clear
	wire [1:0] irq_set  = {mask_expired, nrt_expired && !rx_response};
	wire [1:0] irq_clr  = wr_istat ? w_data_reg[1:0] : 2'h0;
	wire [1:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
	// masked bits stay off the line
	wire       irq_next = |(irq_status_next & ~irq_mask_reg);

	wire sq_delay_done = (squelch_cnt_reg == 12'(rxmt_pkg::SQUELCH_DELAY_CYC));
	wire squelch_next  = auto_sq && mask_running && !mask_expired && sq_delay_done;

	// Read mux
	wire [7:0] timer_status = {3'h0, nrt_state_reg == rxmt_pkg::RXMT_NRT_WAIT, ext_field_sync,
	                           squelch_out, nrt_running, mask_running};
	logic [7:0] rd_byte;
	logic       rd_ok;
	always_comb begin
		rd_ok   = 1'b1;
		rd_byte = 8'h00;
		case (rd_index)
			rxmt_pkg::IDX_RX_MASK_TIME:    rd_byte = rx_mask_time_reg;
			rxmt_pkg::IDX_RESP_TIMEOUT_HI: rd_byte = response_timeout_high_reg;
			rxmt_pkg::IDX_RESP_TIMEOUT_LO: rd_byte = response_timeout_low_reg;
			rxmt_pkg::IDX_TIMER_CTRL:      rd_byte = timer_ctrl_reg;
			rxmt_pkg::IDX_COMMAND:         rd_byte = 8'h00;
			rxmt_pkg::IDX_IRQ_STATUS:      rd_byte = {6'h00, irq_status_reg};
			rxmt_pkg::IDX_IRQ_MASK:        rd_byte = {6'h00, irq_mask_reg};
			rxmt_pkg::IDX_TIMER_STATUS:    rd_byte = timer_status;
			default:                       rd_ok   = 1'b0;
		endcase
	end

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= rxmt_pkg::RESP_OKAY;
			aw_index_reg  <= 8'h00;
			w_data_reg    <= 8'h00;
			w_strb_reg    <= 1'b0;
		end else if (ce) begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				aw_index_reg  <= {2'h0, s_axi_awaddr[7:2]};
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				w_data_reg   <= s_axi_wdata[7:0];
				w_strb_reg   <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? rxmt_pkg::RESP_OKAY : rxmt_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= rxmt_pkg::RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h00_0000, rd_byte};
				s_axi_rresp   <= rd_ok ? rxmt_pkg::RESP_OKAY : rxmt_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// defaults at reset and set-default command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_mask_time_reg          <= rxmt_pkg::RX_MASK_TIME_RESET;
			response_timeout_high_reg <= rxmt_pkg::RESP_TIMEOUT_RESET;
			response_timeout_low_reg  <= rxmt_pkg::RESP_TIMEOUT_RESET;
			timer_ctrl_reg            <= rxmt_pkg::TIMER_CTRL_RESET;
			irq_mask_reg              <= rxmt_pkg::IRQ_MASK_RESET;
		end else if (ce) begin
			if (cmd_default) begin
				rx_mask_time_reg          <= rxmt_pkg::RX_MASK_TIME_RESET;
				response_timeout_high_reg <= rxmt_pkg::RESP_TIMEOUT_RESET;
				response_timeout_low_reg  <= rxmt_pkg::RESP_TIMEOUT_RESET;
				timer_ctrl_reg            <= rxmt_pkg::TIMER_CTRL_RESET;
				irq_mask_reg              <= rxmt_pkg::IRQ_MASK_RESET;
			end
			if (wr_mask)
				rx_mask_time_reg <= w_data_reg;
			if (wr_nrt_hi)
				response_timeout_high_reg <= w_data_reg;
			if (wr_nrt_lo)
				response_timeout_low_reg <= w_data_reg;
			if (wr_ctrl)
				timer_ctrl_reg <= w_data_reg;
			if (wr_imask)
				irq_mask_reg <= w_data_reg[1:0];
		end
	end

	// Timer-side state and outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nrt_state_reg   <= rxmt_pkg::RXMT_NRT_IDLE;
			irq_status_reg  <= 2'h0;
			irq             <= 1'b0;
			squelch_cnt_reg <= 12'h000;
			squelch_out     <= 1'b0;
			rx_data_out     <= 1'b0;
		end else if (ce) begin
			nrt_state_reg  <= nrt_state_next;
			irq_status_reg <= irq_status_next;
			irq            <= irq_next;
			// delay counter restarts at each transmission end
			if (tx_end)
				squelch_cnt_reg <= 12'h000;
			else if (mask_running && !sq_delay_done)
				squelch_cnt_reg <= squelch_cnt_reg + 12'h001;
			squelch_out <= squelch_next && !tx_end;
			rx_data_out <= (mask_running || tx_end) ? 1'b0 : rx_data_sync;
		end
	end

	// full 16-bit count at 64 periods reaches about 309 ms
	// no-response count defaults to zero, so it stays idle until written

endmodule : rxmt_timers
`default_nettype wire

// File: verif/rxmt_timers_props.sv
// Port checker for the receive-mask and no-response timers
`timescale 1ns/1ps
`default_nettype none
module rxmt_timers_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Framing and outputs
	input wire logic        tx_end,
	input wire logic        rx_data_out,
	input wire logic        squelch_out,
	input wire logic        irq
);
	logic [15:0] since_tx_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Cycles since the last end of transmission, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_tx_reg <= 16'hFFFF;
		else if (tx_end)
			since_tx_reg <= 16'h0000;
		else if (since_tx_reg != 16'hFFFF)
			since_tx_reg <= since_tx_reg + 16'h0001;
	end

	property p_mask_hold;
		tx_end |=> !rx_data_out [*8];
	endproperty
	a_mask_hold: assert property (p_mask_hold)
		else $error("receiver output not masked after transmission end");
	property p_mask_min;
		rx_data_out |-> since_tx_reg >= 16'h00FF;
	endproperty
	a_mask_min: assert property (p_mask_min)
		else $error("receiver mask shorter than minimum");
	property p_squelch_start;
		$rose(squelch_out) |-> since_tx_reg >= 16'h0936 && since_tx_reg <= 16'h093C;
	endproperty
	a_squelch_start: assert property (p_squelch_start)
		else $error("squelch started at wrong delay");
	property p_squelch_late;
		squelch_out |-> since_tx_reg >= 16'h0900;
	endproperty
	a_squelch_late: assert property (p_squelch_late)
		else $error("squelch active too early");
	property p_reset_quiet;
		$rose(aresetn) |-> !irq && !squelch_out && !rx_data_out && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active after reset");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped before taken");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data dropped before taken");
	property p_w_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_w_answer: assert property (p_w_answer)
		else $error("write response late");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read data late");
endmodule : rxmt_timers_props
bind rxmt_timers rxmt_timers_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .tx_end, .rx_data_out, .squelch_out, .irq);
`default_nettype wire

// File: verif/rxmt_host_model.sv
// Register bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module rxmt_host_model (
	// Clock
	input  wire logic        aclk,
	// Write channels
	output var  logic [7:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	// Read channels
	output var  logic [7:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready,
	// Wait exhausted
	output var  logic        hang
);
	logic slow;

	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hang, slow} = '0;
	end

	// Slow mode holds off the response ready for a few cycles
	task automatic write_reg(input logic [5:0] idx, input logic [7:0] data, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h000000, data};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (wready) wdata <= ~wdata;
			if (n == 4) bready <= 1'b1;
		end while (!(bvalid && bready) && n < 200);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 200) hang = 1'b1;
	endtask : write_reg

	task automatic read_reg(input logic [5:0] idx, output logic [7:0] data, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= !slow;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n == 4) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 200);
		data = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
		if (n >= 200) hang = 1'b1;
	endtask : read_reg
endmodule : rxmt_host_model
`default_nettype wire

// File: verif/test_rx_mask_and_response_timers.sv
// Self-checking bench for the receive-mask and no-response timers
`timescale 1ns/1ps
`default_nettype none
module test_rx_mask_and_response_timers;
	logic        aclk = 1'b0, aresetn = 1'b0, tick = 1'b1, tx_end = 1'b0, rx_resp = 1'b0, field = 1'b0;
	wire  [7:0]  awaddr, araddr;
	wire  [31:0] wdata, rdata;
	wire  [1:0]  bresp, rresp;
	wire         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	wire         hang, rx_out, sq, irq;
	int          errors = 0, samples_checked = 0, n, s;
	logic [7:0]  d;
	logic [1:0]  r;
	logic [7:0]  mctl [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h04, 8'h20};
	logic [7:0]  mcnt [8] = '{8'h00, 8'h04, 8'h05, 8'hFF, 8'h00, 8'h00, 8'h0B, 8'h32};
	int          mexp [8] = '{256, 256, 320, 16320, 2048, 256, 352, 3200};

	always #4 aclk = ~aclk;

	rxmt_timers DUT (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .carrier_tick(tick), .tx_end,
		.rx_response(rx_resp), .ext_field_in(field), .rx_data_in(1'b1), .rx_data_out(rx_out),
		.squelch_out(sq), .irq);
	rxmt_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .hang);

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rng(input string what, input int v, input int e);
		check(what, 16'((v >= e && v <= e + 8) ? e : v), 16'(e));
	endtask : rng

	task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
		host.write_reg(idx, dat, r);
		check("write response", 16'(r), 16'(rxmt_pkg::RESP_OKAY));
	endtask : wr

	task automatic rd(input string what, input logic [5:0] idx, input logic [7:0] exp);
		host.read_reg(idx, d, r);
		check(what, 16'(d), 16'(exp));
	endtask : rd

	task automatic pulse(input int sel);
		@(posedge aclk);
		if (sel == 0) tx_end <= 1'b1;
		else rx_resp <= 1'b1;
		@(posedge aclk);
		tx_end <= 1'b0;
		rx_resp <= 1'b0;
	endtask : pulse

	// Counts edges until the interrupt; a required rise that never comes ends the run
	task automatic wait_irq(input int bound, input bit must);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (irq !== 1'b1 && n < bound);
		if (must && n >= bound) begin
			errors++;
			complete_run();
		end
	endtask : wait_irq

	task automatic nrt(input logic [7:0] ctl, input logic [7:0] hi, input logic [7:0] lo, input int e);
		wr(rxmt_pkg::IDX_TIMER_CTRL, ctl);
		wr(rxmt_pkg::IDX_RESP_TIMEOUT_HI, hi);
		wr(rxmt_pkg::IDX_RESP_TIMEOUT_LO, lo);
		pulse(0);
		if (e > 0) wait_irq(e + 40, 1'b1);
		if (e > 0) rng("timeout length", n, e);
	endtask : nrt

	task automatic ack(input logic [7:0] st);
		rd("irq status", rxmt_pkg::IDX_IRQ_STATUS, st);
		wr(rxmt_pkg::IDX_IRQ_STATUS, 8'h03);
		rd("irq status cleared", rxmt_pkg::IDX_IRQ_STATUS, 8'h00);
		check("irq cleared", 16'(irq), 16'h0000);
	endtask : ack

	always @(posedge hang) begin
		errors++;
		complete_run();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd("mask reset", rxmt_pkg::IDX_RX_MASK_TIME, 8'h08);
		rd("timeout high reset", rxmt_pkg::IDX_RESP_TIMEOUT_HI, 8'h00);
		rd("timeout low reset", rxmt_pkg::IDX_RESP_TIMEOUT_LO, 8'h00);
		host.read_reg(6'h3F, d, r);
		check("unmapped read", 16'(r), 16'(rxmt_pkg::RESP_SLVERR));
		host.write_reg(6'h3E, 8'h5A, r);
		check("unmapped write", 16'(r), 16'(rxmt_pkg::RESP_SLVERR));
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			wr(rxmt_pkg::IDX_TIMER_CTRL, mctl[i]);
			wr(rxmt_pkg::IDX_RX_MASK_TIME, mcnt[i]);
			pulse(0);
			n = 0;
			s = 0;
			do begin
				@(posedge aclk);
				n++;
				if (sq === 1'b1 && s == 0) s = n;
			end while (rx_out !== 1'b1 && n < 20000);
			rng("mask length", n, mexp[i]);
			if (n >= 20000) complete_run();
			if (mctl[i][5]) rng("squelch start", s, 2360);
			else check("squelch idle", 16'(s), 16'h0000);
			check("squelch end", 16'(sq), 16'h0000);
		end
		$display("test mask done");
		// Shortest mask, so its expiry flag is set before each timeout is acknowledged
		wr(rxmt_pkg::IDX_RX_MASK_TIME, 8'h04);
		wr(rxmt_pkg::IDX_IRQ_STATUS, 8'h03);
		wr(rxmt_pkg::IDX_IRQ_MASK, 8'h02);
		nrt(8'h00, 8'h00, 8'h05, 320);
		ack(8'h03);
		nrt(8'h00, 8'h01, 8'h00, 16384);
		ack(8'h03);
		nrt(8'h01, 8'h00, 8'h02, 8192);
		ack(8'h03);
		nrt(8'h10, 8'h00, 8'h05, 320);
		ack(8'h03);
		nrt(8'h00, 8'h00, 8'h00, 0);
		wait_irq(600, 1'b0);
		ack(8'h02);
		nrt(8'h00, 8'h00, 8'h05, 0);
		repeat (100) @(posedge aclk);
		pulse(1);
		wait_irq(500, 1'b0);
		ack(8'h02);
		wr(rxmt_pkg::IDX_IRQ_MASK, 8'h03);
		nrt(8'h00, 8'h00, 8'h05, 0);
		wait_irq(500, 1'b0);
		check("masked irq", 16'(irq), 16'h0000);
		wr(rxmt_pkg::IDX_IRQ_MASK, 8'h02);
		ack(8'h03);
		nrt(8'h08, 8'h00, 8'h05, 0);
		wait_irq(500, 1'b0);
		check("no field irq", 16'(irq), 16'h0000);
		field <= 1'b1;
		wait_irq(400, 1'b1);
		rng("field start", n, 322);
		ack(8'h03);
		$display("test timeout done");
		wr(rxmt_pkg::IDX_TIMER_CTRL, 8'h00);
		wr(rxmt_pkg::IDX_COMMAND, 8'h01);
		repeat (200) @(posedge aclk);
		wr(rxmt_pkg::IDX_COMMAND, 8'h01);
		wait_irq(400, 1'b1);
		rng("restart length", n, 318);
		ack(8'h01);
		host.slow = 1'b1;
		wr(rxmt_pkg::IDX_RX_MASK_TIME, 8'h33);
		wr(rxmt_pkg::IDX_RESP_TIMEOUT_HI, 8'h12);
		wr(rxmt_pkg::IDX_COMMAND, 8'h02);
		rd("mask default", rxmt_pkg::IDX_RX_MASK_TIME, 8'h08);
		rd("timeout default", rxmt_pkg::IDX_RESP_TIMEOUT_HI, 8'h00);
		$display("test defaults done");
		complete_run();
	end
endmodule : test_rx_mask_and_response_timers
`default_nettype wire
